//--- core/ctf_pkg.sv
// package: offsets, reset values, modes and helpers of the tx select / filter control
package ctf_pkg;
  // buffer count
  localparam int CTF_NBUF = 3;
  // register byte offsets on the apb bus
  localparam logic [7:0] CTF_OFS_CTRL = 8'h00;
  localparam logic [7:0] CTF_OFS_TFLG = 8'h04;
  localparam logic [7:0] CTF_OFS_TARQ = 8'h08;
  localparam logic [7:0] CTF_OFS_TAAK = 8'h0C;
  localparam logic [7:0] CTF_OFS_TBSEL = 8'h10;
  localparam logic [7:0] CTF_OFS_IDAC = 8'h14;
  localparam logic [7:0] CTF_OFS_ISTAT = 8'h18;
  localparam logic [7:0] CTF_OFS_IMASK = 8'h1C;
  // field positions
  localparam int CTF_INIT_REQ_BIT = 0;
  localparam int CTF_MODE_LSB = 4;
  localparam int CTF_HIT_LSB = 0;
  // interrupt event bits
  localparam int CTF_EV_TXE = 0;
  localparam int CTF_EV_ABT = 1;
  localparam int CTF_EV_HIT = 2;
  localparam int CTF_NEV = 3;
  // reset values
  localparam logic [2:0] CTF_RST_TXE = 3'h7;
  localparam logic [2:0] CTF_RST_ZERO3 = 3'h0;
  localparam logic [1:0] CTF_RST_MODE = 2'h0;
  // filter organisation
  typedef enum logic [1:0] {
    CTF_F32 = 2'b00,
    CTF_F16 = 2'b01,
    CTF_F8 = 2'b10,
    CTF_CLOSED = 2'b11
  } ctf_mode_type;
  // isolate the lowest set bit
  function automatic logic [2:0] ctf_lowest(input logic [2:0] v);
    return v & (~v + 3'h1);
  endfunction : ctf_lowest
endpackage : ctf_pkg

//--- core/ctf_reg_if.sv
// interface: register strobes between the apb slave and the control core
`timescale 1ns/10ps
interface ctf_reg_if;
  logic wr; // access-phase write strobe
  logic rd; // setup-phase read strobe
  logic [7:0] addr; // byte address
  logic [7:0] wdata; // write data low byte
  logic [7:0] rdata; // registered read data
  logic hit; // address is mapped
  modport bus (output wr, output rd, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input rd, input addr, input wdata, output rdata, output hit);
endinterface : ctf_reg_if

//--- core/ctf_apb_slave.sv
// apb slave front end, zero wait states
`timescale 1ns/10ps
module ctf_apb_slave (
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core side
  ctf_reg_if.bus regs
);
  // read data is latched by the core in setup, so access can finish at once
  assign regs.rd = i_psel & ~i_penable & ~i_pwrite;
  assign regs.wr = i_psel & i_penable & i_pwrite;
  assign regs.addr = i_paddr;
  assign regs.wdata = i_pwdata[7:0];
  // upper lanes read zero
  assign o_prdata = {24'h000000, regs.rdata};
  assign o_pready = 1'b1;
  // unmapped address answers with an error
  assign o_pslverr = i_psel & i_penable & ~regs.hit;
endmodule : ctf_apb_slave

//--- core/ctf_irq.sv
// sticky interrupt status with mask and one level output
`timescale 1ns/10ps
module ctf_irq #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // events and software
  input wire logic [N-1:0] i_event,
  input wire logic [N-1:0] i_clr,
  input wire logic i_mask_wr,
  input wire logic [N-1:0] i_mask_wdata,
  // state out
  output logic [N-1:0] o_status,
  output logic [N-1:0] o_mask,
  output logic o_irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } ctf_irq_type;
  ctf_irq_type s, next_s;
  // set wins over a same-cycle clear
  always_comb begin
    next_s = s;
    next_s.status = (s.status & ~i_clr) | i_event;
    if (i_mask_wr) begin
      next_s.mask = i_mask_wdata;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign o_status = s.status;
  assign o_mask = s.mask;
  assign o_irq = |(s.status & s.mask);
endmodule : ctf_irq

//--- core/ctf_ctrl.sv
// tx buffer select, abort acknowledge and acceptance control core
//
// Behaviour
// RQ1 - abort acknowledge cleared throughout init mode
// RQ2 - abort acknowledge flags ignore software writes
// RQ3 - one abort acknowledge bit per buffer
// RQ4 - clearing empty flag clears its acknowledge
// RQ5 - selection reset in init, writable outside
// RQ6 - selection reads only its lowest set bit
// RQ7 - lowest set select bit maps window
// RQ8 - scheduled selected buffer blocks window access
// RQ9 - no selection blocks every window access
// RQ10 - software copies empty flags into selection
// RQ11 - acceptance control writable in init only
// RQ12 - mode field picks filter organisation
// RQ13 - closed mode accepts no message
// RQ14 - hit field numbers matching filter
// RQ15 - hit updates on foreground buffer shift
// RQ16 - empty flag set on send or abort
// RQ17 - abort granted only before start/after failure
// RQ18 - all-zero selection reads back zero
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module ctf_ctrl
  import ctf_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // transmit engine
  input wire logic [2:0] i_tx_sent,
  input wire logic [2:0] i_abort_ok,
  output logic [2:0] o_tx_sched,
  output logic [2:0] o_abort_req,
  // transmit buffer window
  input wire logic i_win_req,
  output logic [2:0] o_win_sel,
  output logic o_win_allow,
  // receive side
  input wire logic i_rx_shift,
  input wire logic [2:0] i_rx_hit,
  output logic o_rx_accept_en,
  output logic [1:0] o_accept_mode,
  // mode and interrupt
  output logic o_init_active,
  output logic o_irq
);

  // register state of the core, apart from the interrupt status and mask held in u_irq
  typedef struct packed {
    logic init_req; // init mode request
    logic init_ack; // init mode acknowledge
    logic [2:0] transmit_buffer_empty_flag; // transmit buffer empty flags
    logic [2:0] abt_rq; // abort request bits
    logic [2:0] abt_ak; // abort acknowledge bits
    logic [2:0] sel; // raw selection as written
    ctf_mode_type mode; // acceptance mode field
    logic [2:0] hit; // filter hit indicator
    logic [7:0] rdata; // latched read data
  } ctf_state_type;

  ctf_state_type s; // registered state
  ctf_state_type next_s; // next state

  // register strobes from the bus slave
  ctf_reg_if regs ();

  // decoded helpers
  logic init_act; // both request and acknowledge high
  logic init_off; // both request and acknowledge low
  logic wr_ctrl;
  logic wr_tflg;
  logic wr_tarq;
  logic wr_tbsel;
  logic wr_idac;
  logic [2:0] grant; // abort granted this cycle
  logic [2:0] txe_set; // empty flag set events
  logic [2:0] txe_clr; // software scheduling
  logic [2:0] arq_set; // new abort requests
  logic hit_upd; // hit indicator reload
  logic [2:0] sel_low; // one-hot mapped buffer
  logic [CTF_NEV-1:0] ev; // interrupt events
  logic [CTF_NEV-1:0] ist; // interrupt status
  logic [CTF_NEV-1:0] imask; // interrupt mask
  logic [CTF_NEV-1:0] iclr; // write-one-to-clear

  // bus front end
  ctf_apb_slave u_apb (
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .regs(regs.bus)
  );

  // interrupt status and mask
  ctf_irq #(
    .N(CTF_NEV)
  ) u_irq (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_event(ev),
    .i_clr(iclr),
    .i_mask_wr(regs.wr && regs.addr == CTF_OFS_IMASK),
    .i_mask_wdata(regs.wdata[CTF_NEV-1:0]),
    .o_status(ist),
    .o_mask(imask),
    .o_irq(o_irq)
  );

  // address map check
  always_comb begin
    case (regs.addr)
      CTF_OFS_CTRL, CTF_OFS_TFLG, CTF_OFS_TARQ, CTF_OFS_TAAK,
      CTF_OFS_TBSEL, CTF_OFS_IDAC, CTF_OFS_ISTAT, CTF_OFS_IMASK: begin
        regs.hit = 1'b1;
      end
      default: begin
        regs.hit = 1'b0;
      end
    endcase
  end

  // mode qualifiers
  assign init_act = s.init_req & s.init_ack;
  assign init_off = ~s.init_req & ~s.init_ack;

  // write strobes per register
  assign wr_ctrl = regs.wr && regs.addr == CTF_OFS_CTRL;
  assign wr_tflg = regs.wr && regs.addr == CTF_OFS_TFLG;
  assign wr_tarq = regs.wr && regs.addr == CTF_OFS_TARQ;
  assign wr_tbsel = regs.wr && regs.addr == CTF_OFS_TBSEL;
  assign wr_idac = regs.wr && regs.addr == CTF_OFS_IDAC;
  // no strobe for the acknowledge register: its flags take no write
  // RQ2

  // lowest set select bit picks the window buffer
  assign sel_low = ctf_lowest(s.sel); // RQ7

  // next state
  always_comb begin
    next_s = s;
    // abort only for a scheduled buffer not yet started or failed;
    // a successful send in the same cycle beats the abort
    grant = s.abt_rq & ~s.transmit_buffer_empty_flag & i_abort_ok & ~i_tx_sent; // RQ17
    // send or granted abort empties the buffer
    txe_set = (i_tx_sent & ~s.transmit_buffer_empty_flag) | grant; // RQ16
    // software writes one to schedule, outside init only
    txe_clr = (wr_tflg && !init_act) ? regs.wdata[2:0] : CTF_RST_ZERO3;
    // only scheduled buffers can be asked to abort
    arq_set = (wr_tarq && !init_act) ? (regs.wdata[2:0] & ~s.transmit_buffer_empty_flag) : CTF_RST_ZERO3;
    // closed filter never reloads the hit indicator
    hit_upd = i_rx_shift && s.mode != CTF_CLOSED; // RQ13
    // empty flag: hardware set wins over software clear
    next_s.transmit_buffer_empty_flag = (s.transmit_buffer_empty_flag & ~txe_clr) | txe_set; // RQ16
    // request drops once the buffer is empty again
    next_s.abt_rq = (s.abt_rq | arq_set) & ~txe_set;
    // acknowledge follows the empty flag clear, grant wins
    next_s.abt_ak = (s.abt_ak & ~txe_clr) | grant; // RQ3 RQ4
    // init request bit, acknowledge trails by one cycle
    if (wr_ctrl) begin
      next_s.init_req = regs.wdata[CTF_INIT_REQ_BIT];
    end
    next_s.init_ack = s.init_req;
    // selection takes writes only fully out of init
    if (wr_tbsel && init_off) begin
      next_s.sel = regs.wdata[2:0]; // RQ5
    end
    // organisation field writable in init only
    if (wr_idac && init_act) begin
      next_s.mode = ctf_mode_type'(regs.wdata[CTF_MODE_LSB+:2]); // RQ11 RQ12
    end
    // hit indicator tracks the foreground buffer
    if (hit_upd) begin
      next_s.hit = i_rx_hit; // RQ14 RQ15
    end
    // init mode holds these in reset
    if (init_act) begin
      next_s.abt_ak = CTF_RST_ZERO3; // RQ1
      next_s.abt_rq = CTF_RST_ZERO3;
      next_s.sel = CTF_RST_ZERO3; // RQ5
    end
    // read data latched in the setup cycle
    if (regs.rd) begin
      case (regs.addr)
        CTF_OFS_CTRL: begin
          next_s.rdata = {6'h00, s.init_ack, s.init_req};
        end
        CTF_OFS_TFLG: begin
          next_s.rdata = {5'h00, s.transmit_buffer_empty_flag};
        end
        CTF_OFS_TARQ: begin
          next_s.rdata = {5'h00, s.abt_rq};
        end
        CTF_OFS_TAAK: begin
          next_s.rdata = {5'h00, s.abt_ak}; // RQ3
        end
        CTF_OFS_TBSEL: begin
          // zero selection reads as zero
          next_s.rdata = {5'h00, sel_low}; // RQ6 RQ18
        end
        CTF_OFS_IDAC: begin
          // hit field is read only
          next_s.rdata = {2'h0, s.mode, 1'b0, s.hit}; // RQ11
        end
        CTF_OFS_ISTAT: begin
          next_s.rdata = {5'h00, ist};
        end
        CTF_OFS_IMASK: begin
          next_s.rdata = {5'h00, imask};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
  end

  // event sources for the interrupt block
  assign ev[CTF_EV_TXE] = |txe_set;
  assign ev[CTF_EV_ABT] = |grant;
  assign ev[CTF_EV_HIT] = hit_upd;
  assign iclr = (regs.wr && regs.addr == CTF_OFS_ISTAT) ? regs.wdata[CTF_NEV-1:0] : '0;

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      s.init_req <= 1'b0;
      s.init_ack <= 1'b0;
      s.transmit_buffer_empty_flag <= CTF_RST_TXE;
      s.abt_rq <= CTF_RST_ZERO3;
      s.abt_ak <= CTF_RST_ZERO3;
      s.sel <= CTF_RST_ZERO3;
      s.mode <= ctf_mode_type'(CTF_RST_MODE);
      s.hit <= CTF_RST_ZERO3;
      s.rdata <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign regs.rdata = s.rdata;
  assign o_tx_sched = ~s.transmit_buffer_empty_flag;
  assign o_abort_req = s.abt_rq;
  assign o_win_sel = sel_low; // RQ7
  // window refused with no selection or a scheduled buffer
  assign o_win_allow = i_win_req & |(sel_low & s.transmit_buffer_empty_flag); // RQ8 RQ9
  assign o_rx_accept_en = s.mode != CTF_CLOSED; // RQ13
  assign o_accept_mode = s.mode; // RQ12
  assign o_init_active = init_act;

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  // setup of a selection read
  sequence sel_read_s;
    regs.rd && regs.addr == CTF_OFS_TBSEL;
  endsequence
  // write to the acknowledge register
  sequence ak_write_s;
    regs.wr && regs.addr == CTF_OFS_TAAK && grant == 3'h0 && txe_clr == 3'h0 && !init_act;
  endsequence

  init_ak_clear_a: assert property (init_act |=> s.abt_ak == 3'h0) // RQ1
    else $error("ack not cleared in init");
  ak_write_ro_a: assert property (ak_write_s |=> $stable(s.abt_ak)) // RQ2
    else $error("ack changed by write");
  ak_grant_a: assert property (grant[1] && !init_act |=> s.abt_ak[1] && s.transmit_buffer_empty_flag[1]) // RQ3 RQ16
    else $error("grant did not set ack and empty");
  ak_txe_clr_a: assert property (txe_clr[1] && !grant[1] && !init_act |=> !s.abt_ak[1]) // RQ4
    else $error("ack survived empty clear");
  sel_write_a: assert property (wr_tbsel && init_off |=> s.sel == $past(regs.wdata[2:0])) // RQ5
    else $error("selection write lost");
  sel_read_a: assert property (sel_read_s |=> s.rdata == {5'h00, ctf_lowest($past(s.sel))}) // RQ6
    else $error("selection read not lowest bit");
  // priority spelled out bit by bit, independent of the shared helper
  win_block_a: assert property (o_win_allow |-> i_win_req &&
    (s.sel[0] ? s.transmit_buffer_empty_flag[0] : s.sel[1] ? s.transmit_buffer_empty_flag[1] : (s.sel[2] && s.transmit_buffer_empty_flag[2]))) // RQ8
    else $error("window access while blocked");
  idac_lock_a: assert property (wr_idac && !init_act |=> $stable(s.mode)) // RQ11
    else $error("mode written outside init");
  hit_load_a: assert property (i_rx_shift && s.mode != CTF_CLOSED |=> s.hit == $past(i_rx_hit)) // RQ15
    else $error("hit not reloaded");
  closed_hold_a: assert property (s.mode == CTF_CLOSED && i_rx_shift |=> $stable(s.hit)) // RQ13
    else $error("hit changed while closed");

endmodule : ctf_ctrl

//--- tb/ctf_can_model.sv
// far-side model: transmit engine and receive fifo
`timescale 1ns/10ps
module ctf_can_model (
  // clock
  input wire logic i_ref_clk,
  // towards the core
  output logic [2:0] o_tx_sent,
  output logic [2:0] o_abort_ok,
  output logic o_rx_shift,
  output logic [2:0] o_rx_hit
);
  // idle at time zero
  initial begin
    o_tx_sent = 3'h0;
    o_abort_ok = 3'h0;
    o_rx_shift = 1'b0;
    o_rx_hit = 3'h0;
  end
  // one-cycle success pulse for one buffer
  task automatic send(input int b);
    @(posedge i_ref_clk);
    o_tx_sent <= 3'h1 << b;
    @(posedge i_ref_clk);
    o_tx_sent <= 3'h0;
  endtask : send
  // level: these buffers have not started, so abort may be granted
  task automatic allow(input logic [2:0] v);
    @(posedge i_ref_clk);
    o_abort_ok <= v;
  endtask : allow
  // shift one message into the foreground buffer
  task automatic shift(input logic [2:0] h);
    @(posedge i_ref_clk);
    o_rx_shift <= 1'b1;
    o_rx_hit <= h;
    @(posedge i_ref_clk);
    o_rx_shift <= 1'b0;
    // hit lines take the inverted value once released
    o_rx_hit <= ~h;
  endtask : shift
endmodule : ctf_can_model

//--- tb/can_txsel_abort_filter_ctrl_test.sv
// testbench: register-level checks of the tx select and filter control
`timescale 1ns/10ps
module can_txsel_abort_filter_ctrl_test;
  import ctf_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  // apb
  logic psel, pen, pwr, prdy, perr;
  logic [7:0] pa;
  logic [31:0] pwd, prd, q, v;
  logic e;
  // side signals
  logic win_req, rxs, init, irq, wal, acc_en;
  logic [2:0] sent, aok, rxh, sched, areq, wsel;
  logic [1:0] mode;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  ctf_ctrl uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .i_tx_sent(sent), .i_abort_ok(aok), .o_tx_sched(sched),
    .o_abort_req(areq), .i_win_req(win_req), .o_win_sel(wsel), .o_win_allow(wal),
    .i_rx_shift(rxs), .i_rx_hit(rxh), .o_rx_accept_en(acc_en), .o_accept_mode(mode),
    .o_init_active(init), .o_irq(irq));
  ctf_can_model far (.i_ref_clk(clk), .o_tx_sent(sent), .o_abort_ok(aok),
    .o_rx_shift(rxs), .o_rx_hit(rxh));
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  // single compare point
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // one apb transfer; ends mid-cycle so outputs have settled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // wait for the slave; only the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, q, x);
  endtask : rdc
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    win_req = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc(CTF_OFS_TFLG, 32'h7, "empty rst");
    rdc(CTF_OFS_TAAK, 32'h0, "ack rst");
    rdc(CTF_OFS_TBSEL, 32'h0, "sel rst");
    rdc(CTF_OFS_IDAC, 32'h0, "idac rst");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", e, 32'h1);
    $display("test reset done");
    // schedule buffer 0 then copy empty flags into the selection
    wr(CTF_OFS_TFLG, 32'h1);
    rdc(CTF_OFS_TFLG, 32'h6, "empty");
    wr(CTF_OFS_TBSEL, q);
    rdc(CTF_OFS_TBSEL, 32'h2, "sel copy");
    chk("win sel", wsel, 32'h2);
    for (int i = 0; i < 8; i++) begin
      v = i;
      wr(CTF_OFS_TBSEL, v);
      rdc(CTF_OFS_TBSEL, v[0] ? 1 : v[1] ? 2 : v[2] ? 4 : 0, "sel low");
    end
    @(posedge clk);
    win_req <= 1'b1;
    wr(CTF_OFS_TBSEL, 32'h1);
    chk("win busy", wal, 32'h0);
    wr(CTF_OFS_TBSEL, 32'h6);
    chk("win free", wal, 32'h1);
    wr(CTF_OFS_TBSEL, 32'h0);
    chk("win none", wal, 32'h0);
    @(posedge clk);
    win_req <= 1'b0;
    $display("test select done");
    // abort held off while started, then granted
    wr(CTF_OFS_TFLG, 32'h6);
    wr(CTF_OFS_TARQ, 32'h6);
    chk("abort req", areq, 32'h6);
    rdc(CTF_OFS_TFLG, 32'h0, "no grant");
    far.allow(3'h6);
    rdc(CTF_OFS_TFLG, 32'h6, "grant empty");
    rdc(CTF_OFS_TAAK, 32'h6, "grant ack");
    chk("req cleared", areq, 32'h0);
    far.allow(3'h0);
    wr(CTF_OFS_TAAK, 32'hFF);
    rdc(CTF_OFS_TAAK, 32'h6, "ack ro");
    wr(CTF_OFS_TFLG, 32'h2);
    rdc(CTF_OFS_TAAK, 32'h4, "ack clr");
    far.send(0);
    rdc(CTF_OFS_TFLG, 32'h5, "sent");
    rdc(CTF_OFS_TAAK, 32'h4, "sent no ack");
    chk("sched", sched, 32'h2);
    $display("test abort done");
    // interrupt: raise, mask, clear
    wr(CTF_OFS_ISTAT, 32'h7);
    rdc(CTF_OFS_ISTAT, 32'h0, "stat clr");
    wr(CTF_OFS_IMASK, 32'h1);
    chk("irq idle", irq, 32'h0);
    far.send(1);
    @(negedge clk);
    chk("irq set", irq, 32'h1);
    rdc(CTF_OFS_ISTAT, 32'h1, "stat set");
    wr(CTF_OFS_IMASK, 32'h0);
    chk("irq masked", irq, 32'h0);
    wr(CTF_OFS_IMASK, 32'h1);
    wr(CTF_OFS_ISTAT, 32'h1);
    chk("irq clr", irq, 32'h0);
    $display("test irq done");
    // init mode: forced registers and acceptance control
    wr(CTF_OFS_TBSEL, 32'h4);
    wr(CTF_OFS_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk("init", init, 32'h1);
    rdc(CTF_OFS_TAAK, 32'h0, "ack init");
    rdc(CTF_OFS_TBSEL, 32'h0, "sel init");
    wr(CTF_OFS_TBSEL, 32'h4);
    rdc(CTF_OFS_TBSEL, 32'h0, "sel init wr");
    for (int m = 0; m < 4; m++) begin
      wr(CTF_OFS_IDAC, m << 4);
      chk("mode", mode, m);
      rdc(CTF_OFS_IDAC, m << 4, "idac mode");
    end
    chk("closed", acc_en, 32'h0);
    far.shift(3'h5);
    rdc(CTF_OFS_IDAC, 32'h30, "closed hit");
    wr(CTF_OFS_IDAC, 32'h0);
    wr(CTF_OFS_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    chk("run", init, 32'h0);
    wr(CTF_OFS_IDAC, 32'h30);
    rdc(CTF_OFS_IDAC, 32'h0, "idac run wr");
    far.shift(3'h5);
    rdc(CTF_OFS_IDAC, 32'h5, "hit");
    far.shift(3'h3);
    rdc(CTF_OFS_IDAC, 32'h3, "hit next");
    wr(CTF_OFS_TBSEL, 32'h4);
    rdc(CTF_OFS_TBSEL, 32'h4, "sel run");
    $display("test init done");
    // reset in mid-run puts every register back to its reset value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(CTF_OFS_TBSEL, 32'h0, "sel mid rst");
    rdc(CTF_OFS_IDAC, 32'h0, "idac mid rst");
    chk("sched mid rst", sched, 32'h0);
    $display("test mid reset done");
    complete_run();
  end
endmodule : can_txsel_abort_filter_ctrl_test
